// file: rtl/scc_pkg.sv
// Shared constants and carrier types for the split cache controller
package scc_pkg;
    // Address slicing (physical tag bits 31:12)
    localparam int TAG_W      = 20;
    localparam int TAG_LSB    = 12;
    localparam int DC_IDX_LSB = 4;
    localparam int DC_IDX_W   = 9;
    localparam int IC_IDX_LSB = 5;
    localparam int IC_IDX_W   = 9;
    // Line geometry in doublewords
    localparam int DC_DW      = 2;
    localparam int IC_DW      = 4;
    // Penalty constants
    localparam logic [3:0] DC_PRE_CYC = 4'h3;
    localparam logic [3:0] IC_PRE_CYC = 4'h4;
    // Staging register layout: tag, valid, dirty
    localparam int STG_W      = 22;
    localparam int STG_V_BIT  = 1;
    localparam int STG_D_BIT  = 0;
    // Bus register offsets
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_STAGE  = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_STALL  = 8'h10;
    // AHB encodings
    localparam logic [1:0] HTRANS_NSQ = 2'h2;
    // Maintenance command codes
    typedef enum logic [3:0] {
        OP_NONE = 4'h0, OP_IIDX_INV = 4'h1, OP_DIDX_WBINV = 4'h2,
        OP_ILOAD_TAG = 4'h3, OP_DLOAD_TAG = 4'h4, OP_ISTORE_TAG = 4'h5,
        OP_DSTORE_TAG = 4'h6, OP_DCREATE = 4'h7, OP_IHIT_INV = 4'h8,
        OP_DHIT_INV = 4'h9, OP_DHIT_WBINV = 4'hA, OP_IFILL = 4'hB,
        OP_DHIT_WB = 4'hC, OP_IHIT_WB = 4'hD
    } scc_op_type;
    // Memory request carrier
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [63:0] wdata;
    } scc_mreq_type;
    // Tag array entry carrier
    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic             valid;
        logic             dirty;
    } scc_tag_type;
endpackage

// file: rtl/scc_mem.sv
// Single-port array with registered read data
`timescale 1ns/1ps
`default_nettype none
module scc_mem #(
    parameter int W = 64,
    parameter int A = 9
) (
    // Clock
    input  wire logic         clk,
    // Access port
    input  wire logic         we,
    input  wire logic [A-1:0] addr,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] rdata
);
    // Storage, not reset: contents survive reset
    logic [W-1:0] mem [0:(1<<A)-1];
    // Write and registered read
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule
`default_nettype wire

// file: rtl/scc_top.sv
// Split instruction/data cache controller with AHB-Lite maintenance port
// Notes on behaviour
// - Index invalidate clears icache line, no traffic
// - Index writeback-invalidate: flush dirty, then invalidate
// - Load/store tag via staging register
// - Create dirty exclusive: flush dirty, set tag
// - Hit invalidate only on matching address
// - Hit writeback-invalidate: flush only on dirty hit, invalidate on any hit
// - Fill loads icache line from memory
// - Hit writeback leaves line valid clean
// - Icache hit writeback writes unconditionally
// - Stores stay in cache until eviction
// - Replaced line written back becomes invalid
// - Miss: address out, victim to flush buffer
// - Narrow store merges into fetched doubleword
// - Data stall is three, align, access, one
// - Load miss: dirty victim written after install
// - Store miss: merge, then flush victim
// - Data refill budget per system cycles
// - Icache refill sequential, resume after line
// - Instruction stall is four, align, access, one
// - Instruction refill transfers eight system cycles
// - Dcache three states, icache two
// - Reset leaves line states untouched
// - Icache tag twenty bits plus valid
// - Dcache tag twenty bits, valid, dirty
// - Index by VA 12:4 and 13:5
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module scc_top
    import scc_pkg::*;
#(
    parameter int DC_IDX = DC_IDX_W,
    parameter int IC_IDX = IC_IDX_W
) (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        HREADY,
    // Instruction fetch port
    input  wire logic        IF_REQ,
    input  wire logic [31:0] IF_VADDR,
    input  wire logic [31:0] IF_PADDR,
    output logic      [63:0] IF_RDATA,
    output logic             IF_STALL,
    // Data port
    input  wire logic        LS_REQ,
    input  wire logic        LS_WRITE,
    input  wire logic [7:0]  LS_BE,
    input  wire logic [31:0] LS_VADDR,
    input  wire logic [31:0] LS_PADDR,
    input  wire logic [63:0] LS_WDATA,
    output logic      [63:0] LS_RDATA,
    output logic             LS_STALL,
    // Memory side (external agent, same clock)
    output logic             MEM_REQ,
    output logic             MEM_WRITE,
    output logic      [31:0] MEM_ADDR,
    output logic      [63:0] MEM_WDATA,
    input  wire logic        MEM_ACK,
    input  wire logic        MEM_RVALID,
    input  wire logic [63:0] MEM_RDATA,
    input  wire logic        SYS_ALIGN
);
    typedef enum {S_IDLE, S_LOOK, S_FLUSH_RD, S_FETCH, S_FLUSH_WR,
                  S_DONE} scc_st_type;
    // Controller state
    scc_st_type    st_r;
    scc_op_type    op_r;           // Active maintenance command (not written on a miss)
    logic          is_ic_r;        // Operation targets icache
    logic          miss_r;         // Pipeline miss, not a command
    logic          st_wr_r;        // Miss was a store
    logic [31:0]   pa_r;           // Physical address
    logic [8:0]    idx_r;          // Line index
    logic [1:0]    dw_r;           // Doubleword counter
    logic [63:0]   sdata_r;        // Store data to merge
    logic [7:0]    sbe_r;          // Store byte enables
    logic [STG_W-1:0] stg_r;       // Tag staging register
    logic [63:0]   fbuf_r [0:1];   // Flush buffer
    logic [31:0]   faddr_r;        // Flush buffer address
    logic          fpend_r;        // Flush buffer holds a victim
    logic          req_r;          // Memory request outstanding
    logic [15:0]   stall_r;        // Last stall length
    logic [15:0]   cnt_r;          // Running stall count
    // Tag arrays are not reset (line states survive reset)
    // dcache and icache states
    scc_tag_type   dtag [0:(1<<DC_IDX)-1];
    scc_tag_type   itag [0:(1<<IC_IDX)-1];
    // Array ports
    logic          dm_we, im_we;
    logic [9:0]    dm_a;
    logic [10:0]   im_a;
    logic [63:0]   dm_wd, im_wd, dm_rd, im_rd;
    // Bus phase registers
    logic          bw_r, bv_r;
    logic [7:0]    ba_r;
    logic [31:0]   cmd_addr_r;

    logic [8:0]    d_idx, i_idx;
    assign d_idx = LS_VADDR[DC_IDX_LSB +: DC_IDX_W];
    assign i_idx = IF_VADDR[IC_IDX_LSB +: IC_IDX_W];
    scc_tag_type   dt, it, ct;
    assign dt = dtag[d_idx];
    assign it = itag[i_idx];
    assign ct = is_ic_r ? itag[idx_r] : dtag[idx_r];
    logic d_hit, i_hit, c_hit;
    assign d_hit = dt.valid && dt.tag == LS_PADDR[TAG_LSB +: TAG_W];
    assign i_hit = it.valid && it.tag == IF_PADDR[TAG_LSB +: TAG_W];
    assign c_hit = ct.valid && ct.tag == pa_r[TAG_LSB +: TAG_W];
    // Victim line byte address: tag above the untranslated index bits
    logic [31:0]   vict_a;
    assign vict_a = is_ic_r ? {ct.tag, idx_r[6:0], 5'h00} :
                              {ct.tag, idx_r[7:0], 4'h0};

    // Data arrays
    scc_mem #(.W(64), .A(10)) u_dmem (
        .clk(SYS_CLK), .we(dm_we), .addr(dm_a), .wdata(dm_wd),
        .rdata(dm_rd));
    scc_mem #(.W(64), .A(11)) u_imem (
        .clk(SYS_CLK), .we(im_we), .addr(im_a), .wdata(im_wd),
        .rdata(im_rd));

    // Merge of store bytes into fetched doubleword
    function automatic logic [63:0] merge(input logic [63:0] f,
        input logic [63:0] s, input logic [7:0] be);
        logic [63:0] r;
        r = f;
        for (int b = 0; b < 8; b++) begin
            if (be[b]) r[b*8 +: 8] = s[b*8 +: 8];
        end
        return r;
    endfunction

    logic busy;
    assign busy = st_r != S_IDLE;
    logic fill_wr;
    assign fill_wr = st_r == S_FETCH && MEM_RVALID;
    // Array address and write selection
    always_comb begin
        dm_we = 1'b0;
        im_we = 1'b0;
        dm_wd = 64'h0;
        im_wd = MEM_RDATA;
        dm_a  = {d_idx, LS_VADDR[3]};
        im_a  = {i_idx, IF_VADDR[4:3]};
        if (busy) begin
            dm_a = {idx_r, dw_r[0]};
            im_a = {idx_r, dw_r};
        end
        // merge narrow store into fetched data
        if (fill_wr && !is_ic_r) begin
            dm_we = 1'b1;
            dm_wd = (st_wr_r && dw_r[0] == pa_r[3]) ?
                    merge(MEM_RDATA, sdata_r, sbe_r) : MEM_RDATA;
        end else if (!busy && LS_REQ && LS_WRITE && d_hit) begin
            // store hit absorbed in cache only
            dm_we = 1'b1;
            dm_wd = merge(dm_rd, LS_WDATA, LS_BE);
        end
        if (fill_wr && is_ic_r) im_we = 1'b1;
    end

    // hit returns registered array data, no stall while the controller is idle
    assign IF_RDATA = im_rd;
    assign LS_RDATA = dm_rd;
    assign IF_STALL = (IF_REQ && !i_hit) || (busy && is_ic_r);
    assign LS_STALL = (LS_REQ && !d_hit) || (busy && !is_ic_r);

    // Main sequencer
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            st_r <= S_IDLE;
            op_r <= OP_NONE;
            is_ic_r <= 1'b0;
            miss_r <= 1'b0;
            st_wr_r <= 1'b0;
            pa_r <= 32'h0;
            idx_r <= 9'h0;
            dw_r <= 2'h0;
            sdata_r <= 64'h0;
            sbe_r <= 8'h0;
            fpend_r <= 1'b0;
            faddr_r <= 32'h0;
            req_r <= 1'b0;
            cnt_r <= 16'h0;
            stall_r <= 16'h0;
        end else begin
            cnt_r <= busy ? cnt_r + 16'h1 : 16'h0;
            unique case (st_r)
                S_IDLE: begin
                    dw_r <= 2'h0;
                    if (bv_r && bw_r && ba_r == OFS_CMD) begin
                        op_r <= scc_op_type'(HWDATA[3:0]);
                        is_ic_r <= HWDATA[3:0] inside {OP_IIDX_INV,
                            OP_ILOAD_TAG, OP_ISTORE_TAG, OP_IHIT_INV,
                            OP_IFILL, OP_IHIT_WB};
                        pa_r <= cmd_addr_r;
                        idx_r <= HWDATA[3:0] inside {OP_IIDX_INV,
                            OP_ILOAD_TAG, OP_ISTORE_TAG, OP_IHIT_INV,
                            OP_IFILL, OP_IHIT_WB} ?
                            cmd_addr_r[IC_IDX_LSB +: IC_IDX_W] :
                            cmd_addr_r[DC_IDX_LSB +: DC_IDX_W];
                        miss_r <= 1'b0;
                        st_r <= S_LOOK;
                    end else if (LS_REQ && !d_hit) begin
                        miss_r <= 1'b1;
                        is_ic_r <= 1'b0;
                        st_wr_r <= LS_WRITE;
                        pa_r <= LS_PADDR;
                        idx_r <= d_idx;
                        sdata_r <= LS_WDATA;
                        sbe_r <= LS_BE;
                        st_r <= S_LOOK;
                    end else if (IF_REQ && !i_hit) begin
                        miss_r <= 1'b1;
                        is_ic_r <= 1'b1;
                        st_wr_r <= 1'b0;
                        pa_r <= {IF_PADDR[31:5], 5'h00};
                        idx_r <= i_idx;
                        st_r <= S_LOOK;
                    end
                end
                S_LOOK: begin
                    st_r <= S_DONE;
                    if (miss_r) begin
                        fpend_r <= !is_ic_r && ct.valid && ct.dirty;
                        faddr_r <= vict_a;
                        // Victim copy starts at doubleword zero
                        dw_r <= (is_ic_r || (ct.valid && ct.dirty)) ?
                                2'h0 : {1'b0, pa_r[3]};
                        st_r <= (!is_ic_r && ct.valid && ct.dirty) ?
                                S_FLUSH_RD : S_FETCH;
                    end else if (op_r inside {OP_DIDX_WBINV, OP_DCREATE}
                                 && ct.valid && ct.dirty
                                 && !(op_r == OP_DCREATE && c_hit)) begin
                        fpend_r <= 1'b1;
                        faddr_r <= vict_a;
                        st_r <= S_FLUSH_RD;
                    end else if ((op_r inside {OP_DHIT_WBINV, OP_DHIT_WB}
                                 && c_hit && ct.dirty) ||
                                 (op_r == OP_IHIT_WB && c_hit)) begin
                        fpend_r <= 1'b1;
                        faddr_r <= vict_a;
                        st_r <= S_FLUSH_RD;
                    end else if (op_r == OP_IFILL) begin
                        dw_r <= 2'h0;
                        st_r <= S_FETCH;
                    end
                end
                S_FLUSH_RD: begin
                    // Copy victim doublewords out of the array
                    dw_r <= dw_r + 2'h1;
                    if (dw_r == 2'(DC_DW + (is_ic_r ? IC_DW : 0))) begin
                        dw_r <= miss_r ? {1'b0, pa_r[3]} : 2'h0;
                        st_r <= miss_r ? S_FETCH : S_FLUSH_WR;
                    end
                end
                S_FETCH: begin
                    // wait for aligned cycle then request
                    if (!req_r && SYS_ALIGN) req_r <= 1'b1;
                    if (MEM_RVALID) begin
                        dw_r <= dw_r + 2'h1;
                        // Data line ends on the non-critical doubleword
                        if (is_ic_r ? (dw_r == 2'(IC_DW-1)) :
                                      (dw_r[0] == ~pa_r[3])) begin
                            req_r <= 1'b0;
                            st_r <= fpend_r ? S_FLUSH_WR : S_DONE;
                            dw_r <= 2'h0;
                        end
                    end
                end
                S_FLUSH_WR: begin
                    if (MEM_ACK) begin
                        dw_r <= dw_r + 2'h1;
                        if (dw_r == 2'(DC_DW-1)) begin
                            fpend_r <= 1'b0;
                            st_r <= S_DONE;
                        end
                    end
                end
                S_DONE: begin
                    stall_r <= cnt_r + 16'(miss_r ?
                        (is_ic_r ? IC_PRE_CYC : DC_PRE_CYC) : 4'h0);
                    st_r <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // Flush buffer fill from registered array data
    always_ff @(posedge SYS_CLK) begin
        if (st_r == S_FLUSH_RD && dw_r != 2'h0) begin
            fbuf_r[dw_r[0] ^ 1'b1] <= is_ic_r ? im_rd : dm_rd;
        end
    end

    // Tag array updates (no reset: states survive reset)
    always_ff @(posedge SYS_CLK) begin
        if (st_r == S_LOOK && !miss_r) begin
            unique case (op_r)
                OP_IIDX_INV: itag[idx_r].valid <= 1'b0;
                OP_ISTORE_TAG: itag[idx_r] <= stg_r;
                OP_DSTORE_TAG: dtag[idx_r] <= stg_r;
                OP_IHIT_INV: if (c_hit) itag[idx_r].valid <= 1'b0;
                OP_DHIT_INV: if (c_hit) dtag[idx_r].valid <= 1'b0;
                default: ;
            endcase
        end
        if (st_r == S_DONE && !miss_r) begin
            unique case (op_r)
                OP_DIDX_WBINV, OP_DHIT_WBINV:
                    if (op_r == OP_DIDX_WBINV || c_hit) begin
                        // Invalid line carries no dirty mark
                        dtag[idx_r].valid <= 1'b0;
                        dtag[idx_r].dirty <= 1'b0;
                    end
                OP_DCREATE: dtag[idx_r] <=
                    '{tag: pa_r[TAG_LSB +: TAG_W], valid: 1'b1, dirty: 1'b1};
                OP_DHIT_WB: if (c_hit) dtag[idx_r].dirty <= 1'b0;
                OP_IFILL: itag[idx_r] <=
                    '{tag: pa_r[TAG_LSB +: TAG_W], valid: 1'b1, dirty: 1'b0};
                default: ;
            endcase
        end
        if (st_r == S_FETCH && MEM_RVALID) begin
            if (is_ic_r) begin
                itag[idx_r] <= '{tag: pa_r[TAG_LSB +: TAG_W],
                                 valid: 1'b1, dirty: 1'b0};
            end else begin
                dtag[idx_r] <= '{tag: pa_r[TAG_LSB +: TAG_W],
                                 valid: 1'b1, dirty: st_wr_r};
            end
        end
        if (!busy && LS_REQ && LS_WRITE && d_hit) dtag[d_idx].dirty <= 1'b1;
    end

    // Memory request outputs
    always_comb begin
        MEM_REQ   = (st_r == S_FETCH && req_r) || st_r == S_FLUSH_WR;
        MEM_WRITE = st_r == S_FLUSH_WR;
        MEM_ADDR  = st_r == S_FLUSH_WR ?
                    {faddr_r[31:4], dw_r[0], 3'h0} : pa_r;
        MEM_WDATA = fbuf_r[dw_r[0]];
    end

    // AHB address phase capture
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            bv_r <= 1'b0;
            bw_r <= 1'b0;
            ba_r <= 8'h0;
        end else if (HREADY) begin
            bv_r <= HSEL && HTRANS == HTRANS_NSQ;
            bw_r <= HWRITE;
            ba_r <= HADDR[7:0];
        end
    end

    // Register writes and staging register
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            cmd_addr_r <= 32'h0;
            stg_r <= '0;
        end else begin
            if (bv_r && bw_r && ba_r == OFS_ADDR) cmd_addr_r <= HWDATA;
            if (bv_r && bw_r && ba_r == OFS_STAGE) stg_r <= HWDATA[STG_W-1:0];
            if (st_r == S_LOOK && op_r == OP_ILOAD_TAG && !miss_r)
                stg_r <= {ct.tag, ct.valid, 1'b0};
            if (st_r == S_LOOK && op_r == OP_DLOAD_TAG && !miss_r)
                stg_r <= ct;
        end
    end

    // Read mux, command writes wait while busy
    assign HREADYOUT = !(bv_r && bw_r && ba_r == OFS_CMD && busy);
    assign HRESP = 1'b0;
    always_comb begin
        HRDATA = 32'h0;
        if (bv_r && !bw_r) begin
            unique case (ba_r)
                OFS_ADDR:   HRDATA = cmd_addr_r;
                OFS_STAGE:  HRDATA = {10'h0, stg_r};
                OFS_STATUS: HRDATA = {30'h0, fpend_r, busy};
                OFS_STALL:  HRDATA = {16'h0, stall_r};
                default:    HRDATA = 32'h0;
            endcase
        end
    end

    // invalidate happens within two cycles of command
    a_idx_inv_fast: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        st_r == S_LOOK && op_r == OP_IIDX_INV && !miss_r
        |=> st_r == S_DONE) else $error("index invalidate made traffic");
    a_miss_stall: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        st_r == S_FETCH && !is_ic_r |-> LS_STALL)
        else $error("data miss without stall");
    a_wb_only: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        MEM_WRITE |-> fpend_r) else $error("memory write without victim");
    a_align_wait: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        $rose(req_r) |-> $past(SYS_ALIGN)) else $error("unaligned request");
    // flush follows fetch only when a victim is pending
    sequence fetch_end_s;
        st_r == S_FETCH ##1 st_r == S_FLUSH_WR;
    endsequence
    a_victim_after: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        fetch_end_s |-> fpend_r) else $error("flush without victim");
    a_hit_nostall: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        !busy && IF_REQ && i_hit |-> !IF_STALL) else $error("hit stalled");
    a_done_clean: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        st_r == S_DONE |-> !fpend_r) else $error("flush buffer not drained");
    a_cmd_look: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        !busy && bv_r && bw_r && ba_r == OFS_CMD |=> st_r == S_LOOK)
        else $error("command not started");
endmodule
`default_nettype wire

// file: dv/scc_mem_model.sv
// Same-clock memory agent answering refills and write-backs
`timescale 1ns/1ps
`default_nettype none
module scc_mem_model #(
    parameter int DLY = 2
) (
    // Clock
    input  wire logic        clk,
    // Request from the cache
    input  wire logic        req,
    input  wire logic        wr,
    input  wire logic [31:0] addr,
    // Answers and system edge marker
    output logic             ack,
    output logic             rvalid,
    output logic      [63:0] rdata,
    output logic             align
);
    int cnt = 0;
    initial {ack, rvalid, rdata, align} = '0;
    // memory time M, one doubleword per answer
    always @(posedge clk) begin
        align <= ~align;
        ack <= 1'b0;
        rvalid <= 1'b0;
        rdata <= ~rdata;
        if (req && cnt == DLY) begin
            cnt <= 0;
            ack <= wr;
            rvalid <= ~wr;
            if (!wr) rdata <= {addr, ~addr};
        end else begin
            cnt <= req ? cnt + 1 : 0;
        end
    end
endmodule
`default_nettype wire

// file: dv/test_split_cache_controller.sv
// Self-checking bench for the split cache controller
`timescale 1ns/1ps
`default_nettype none
module test_split_cache_controller;
    import scc_pkg::*;
    // Row: staging in, address, command, readback, expected, mask
    typedef struct packed {
        logic [31:0] sin;
        logic [31:0] adr;
        scc_op_type  op;
        scc_op_type  lop;
        logic [31:0] exp;
        logic [31:0] msk;
    } scc_row_type;
    localparam logic [31:0] A = 32'h0000_1230;
    localparam logic [31:0] B = 32'h0000_3230;
    localparam logic [31:0] F = 32'h003F_FFFF;
    localparam logic [31:0] V = 32'h003F_FFFE;
    logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, va = '0, hrdata, q, maddr;
    logic [1:0]  htrans = '0;
    logic        if_req = 1'b0, ls_req = 1'b0;
    logic        hready, hresp, if_stall, ls_stall, mreq, mwr, mack;
    logic        mrv, align;
    logic [63:0] if_rd, ls_rd, mwd, mrd;
    int          fails = 0, checks_done = 0, n;
    scc_row_type rows [12] = '{
        '{32'h7, A, OP_DSTORE_TAG, OP_DLOAD_TAG, 32'h7, F},
        '{32'h0, B, OP_DHIT_INV, OP_DLOAD_TAG, 32'h7, F},
        '{32'h0, A, OP_DHIT_WB, OP_DLOAD_TAG, 32'h6, F},
        '{32'h7, A, OP_DSTORE_TAG, OP_DLOAD_TAG, 32'h7, F},
        '{32'h0, A, OP_DHIT_WBINV, OP_DLOAD_TAG, 32'h0, 32'h3},
        '{32'h0, A, OP_DCREATE, OP_DLOAD_TAG, 32'h6, V},
        '{32'h0, A, OP_DIDX_WBINV, OP_DLOAD_TAG, 32'h0, 32'h3},
        '{32'h6, A, OP_ISTORE_TAG, OP_ILOAD_TAG, 32'h6, V},
        '{32'h0, A, OP_IHIT_WB, OP_ILOAD_TAG, 32'h6, V},
        '{32'h0, A, OP_IHIT_INV, OP_ILOAD_TAG, 32'h0, 32'h2},
        '{32'h0, A, OP_IFILL, OP_ILOAD_TAG, 32'h6, V},
        '{32'h0, A, OP_IIDX_INV, OP_ILOAD_TAG, 32'h0, 32'h2}};
    scc_top dut (.SYS_CLK(clk), .RESETN(rstn), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .HREADY(hready), .IF_REQ(if_req), .IF_VADDR(va),
        .IF_PADDR(va), .IF_RDATA(if_rd), .IF_STALL(if_stall),
        .LS_REQ(ls_req), .LS_WRITE(1'b0), .LS_BE(8'hFF), .LS_VADDR(va),
        .LS_PADDR(va), .LS_WDATA(64'h0), .LS_RDATA(ls_rd),
        .LS_STALL(ls_stall), .MEM_REQ(mreq), .MEM_WRITE(mwr),
        .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_ACK(mack),
        .MEM_RVALID(mrv), .MEM_RDATA(mrd), .SYS_ALIGN(align));
    scc_mem_model #(.DLY(2)) mem (.clk(clk), .req(mreq), .wr(mwr),
        .addr(maddr), .ack(mack), .rvalid(mrv), .rdata(mrd),
        .align(align));
    initial forever #2 clk = ~clk;
    // Compare and count
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One AHB single word transfer; read data lands in q
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NSQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // Issue a command and poll until idle
    task automatic cmd(input scc_op_type op);
        bus(1'b1, OFS_CMD, {28'h0, op});
        do bus(1'b0, OFS_STATUS, '0); while (q[0] !== 1'b0);
    endtask
    // Stage, address, command, tag readback
    task automatic run(input scc_row_type r);
        bus(1'b1, OFS_STAGE, r.sin);
        bus(1'b1, OFS_ADDR, r.adr);
        cmd(r.op);
        cmd(r.lop);
        bus(1'b0, OFS_STAGE, '0);
    endtask
    task automatic complete_run;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run;
    end
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            run(rows[i]);
            chk({32'h0, q & rows[i].msk}, {32'h0, rows[i].exp});
        end
        // Line state across a reset
        run('{32'h7, A, OP_DSTORE_TAG, OP_DLOAD_TAG, 32'h7, F});
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        bus(1'b1, OFS_ADDR, A);
        cmd(OP_DLOAD_TAG);
        bus(1'b0, OFS_STAGE, '0);
        chk({32'h0, q}, 64'h7);
        // Load miss on a dirty line, critical doubleword second
        va <= B | 32'h8;
        ls_req <= 1'b1;
        n = 0;
        do @(posedge clk); while (ls_stall !== 1'b0 && ++n < 200);
        if (n >= 200) fails++;
        @(posedge clk);
        chk(ls_rd, {B | 32'h8, ~(B | 32'h8)});
        chk({63'h0, ls_stall}, 64'h0);
        ls_req <= 1'b0;
        bus(1'b0, OFS_STALL, '0);
        chk({63'h0, q > 32'd5}, 64'h1);
        bus(1'b1, OFS_ADDR, B);
        cmd(OP_DLOAD_TAG);
        bus(1'b0, OFS_STAGE, '0);
        chk({32'h0, q}, 64'hE);
        complete_run;
    end
endmodule
`default_nettype wire
